/* inc/mcb_map.vh */
// register map, field positions, reset values and timing for the csr bridge and auto pause
// What this block does
// - busy write launches indexed mac register access
// - busy stays set until access completes
// - bit 30 one reads, zero writes
// - command bits 7-0 index the mac register
// - data register holds write value, read result
// - transmitter disabled means no pause, no jam
// - high watermark, 64-byte units, triggers flow control
// - full duplex with bit 0 set sends one pause at high
// - half duplex jams matching frames for duration
// - below low watermark sends zero-time pause
// - zero pause only after high pause, enabled
// - jam duration field, ignored in full duplex
// - bit 3 jams multicast frames in half duplex
// - bit 2 jams broadcast frames in half duplex
// - bit 1 jams own-address frames in half duplex
// - bit 0 triggers on any frame, overrides 3:1
// - duration code table, plus 2.2us at 10Mb
`ifndef MCB_MAP_VH
`define MCB_MAP_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define MCB_CSR_CMD_OFS 8'hA4
`define MCB_CSR_DATA_OFS 8'hA8
`define MCB_AUTO_CFG_OFS 8'hAC

// ----------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------
`define MCB_CMD_BUSY_BIT 31
`define MCB_CMD_RNW_BIT 30
`define MCB_CMD_IDX_HI 7
`define MCB_CMD_IDX_LO 0

// ----------------------------------------------------------------------
// auto pause config fields
// ----------------------------------------------------------------------
`define MCB_CFG_HI_MSB 23
`define MCB_CFG_HI_LSB 16
`define MCB_CFG_LO_MSB 15
`define MCB_CFG_LO_LSB 8
`define MCB_CFG_DUR_MSB 7
`define MCB_CFG_DUR_LSB 4
`define MCB_CFG_MULT_BIT 3
`define MCB_CFG_BRD_BIT 2
`define MCB_CFG_OWN_BIT 1
`define MCB_CFG_ANY_BIT 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MCB_DATA_RST 32'h00000000
`define MCB_IDX_RST 8'h00
`define MCB_WM_RST 8'h00
`define MCB_DUR_RST 4'h0
`define MCB_TRIG_RST 4'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MCB_WM_UNIT_SHIFT 6
`define MCB_CLK_MHZ 25
`define MCB_JAM_T0_US 5
`define MCB_JAM_T1_US 10
`define MCB_JAM_T2_US 15
`define MCB_JAM_T3_US 25
`define MCB_JAM_STEP_US 50
`define MCB_JAM_STEP_BASE 3
`define MCB_JAM_10M_EXTRA_NS 2200
`define MCB_NS_PER_US 1000

`endif

/* src/mcb_jam_timer.v */
// back pressure duration timer for half duplex jamming
`timescale 1ns/100ps
`include "mcb_map.vh"

module mcb_jam_timer #(
  parameter CYC_PER_US = `MCB_CLK_MHZ
) (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire cancel,
  input wire [3:0] code,
  input wire speed_100,
  output wire active
);

  reg [15:0] count;

  // duration code to clock cycles
  function [15:0] jam_cycles;
    input [3:0] dur_code;
    input fast;
    reg [31:0] us;
    reg [31:0] cyc;
    begin
      case (dur_code)
        4'h0: us = `MCB_JAM_T0_US;
        4'h1: us = `MCB_JAM_T1_US;
        4'h2: us = `MCB_JAM_T2_US;
        4'h3: us = `MCB_JAM_T3_US;
        default: us = `MCB_JAM_STEP_US * ({28'h0, dur_code} - `MCB_JAM_STEP_BASE);
      endcase
      cyc = us * CYC_PER_US;
      if (!fast) begin
        cyc = cyc + (`MCB_JAM_10M_EXTRA_NS * CYC_PER_US) / `MCB_NS_PER_US;
      end
      jam_cycles = cyc[15:0];
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
    end else if (cancel) begin
      count <= 16'h0000;
    end else if (start) begin
      count <= jam_cycles(code, speed_100);
    end else if (count != 16'h0000) begin
      count <= count - 16'h0001;
    end
  end

  assign active = (count != 16'h0000);

endmodule // mcb_jam_timer

/* src/mcb_top.v */
// csr bridge and automatic pause / back pressure controller with apb slave
`timescale 1ns/100ps
`include "mcb_map.vh"

module mcb_top #(
  parameter LEVEL_W = 14,
  parameter CYC_PER_US = `MCB_CLK_MHZ
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  output reg mac_csr_req,
  output reg mac_csr_read,
  output reg [7:0] mac_csr_index,
  output reg [31:0] mac_csr_wdata,
  input wire [31:0] mac_csr_rdata,
  input wire mac_csr_ack,
  input wire tx_enable,
  input wire full_duplex,
  input wire speed_100,
  input wire [LEVEL_W-1:0] rx_fifo_bytes,
  input wire [15:0] pause_time_value,
  input wire rx_preamble,
  input wire rx_addr_done,
  input wire rx_is_multicast,
  input wire rx_is_broadcast,
  input wire rx_is_own,
  output wire pause_req,
  output reg [15:0] pause_time,
  input wire pause_ack,
  output wire back_pressure
);

  // ----------------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------------
  localparam FC_IDLE = 1'b0;
  localparam FC_PAUSED = 1'b1;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg [7:0] high_mark;
  reg [7:0] low_mark;
  reg [3:0] jam_duration;
  reg trigger_on_multicast;
  reg trigger_on_broadcast;
  reg trigger_on_own_address;
  reg trigger_on_every_frame;
  reg pause_pending;
  reg fc_state;
  reg next_fc_state;
  reg next_pause_pending;
  reg [15:0] next_pause_time;
  wire setup_phase;
  wire access_wr;
  wire hit_cmd;
  wire hit_data;
  wire hit_cfg;
  wire hit_any;
  wire reached_high;
  wire below_low;
  wire fd_enabled;
  wire hd_enabled;
  wire frame_match;
  wire jam_start;
  wire jam_active;
  wire [31:0] cmd_view;
  wire [31:0] cfg_view;

  // watermark in 64-byte units to a byte level
  function [LEVEL_W+1:0] mark_bytes;
    input [7:0] mark;
    begin
      mark_bytes = {{(LEVEL_W-12){1'b0}}, mark, 6'h00};
    end
  endfunction

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  assign setup_phase = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign hit_cmd = (paddr == `MCB_CSR_CMD_OFS);
  assign hit_data = (paddr == `MCB_CSR_DATA_OFS);
  assign hit_cfg = (paddr == `MCB_AUTO_CFG_OFS);
  assign hit_any = hit_cmd | hit_data | hit_cfg;

  // reserved bits read as zero
  assign cmd_view = {mac_csr_req, mac_csr_read, 22'h000000, mac_csr_index};
  assign cfg_view = {8'h00, high_mark, low_mark, jam_duration,
                     trigger_on_multicast, trigger_on_broadcast,
                     trigger_on_own_address, trigger_on_every_frame};

  // read data captured in setup so it comes from a flop in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pslverr <= ~hit_any;
      if (pwrite) begin
        prdata <= 32'h00000000;
      end else if (hit_cmd) begin
        prdata <= cmd_view;
      end else if (hit_data) begin
        prdata <= mac_csr_wdata;
      end else if (hit_cfg) begin
        prdata <= cfg_view;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // csr bridge
  // ----------------------------------------------------------------------
  // mac_csr_req is the busy bit; bus writes to command and data are ignored while it is set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_csr_req <= 1'b0;
      mac_csr_read <= 1'b0;
      mac_csr_index <= `MCB_IDX_RST;
    end else if (mac_csr_req) begin
      if (mac_csr_ack) begin
        mac_csr_req <= 1'b0;
      end
    end else if (access_wr && hit_cmd) begin
      mac_csr_req <= pwdata[`MCB_CMD_BUSY_BIT];
      mac_csr_read <= pwdata[`MCB_CMD_RNW_BIT];
      mac_csr_index <= pwdata[`MCB_CMD_IDX_HI:`MCB_CMD_IDX_LO];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_csr_wdata <= `MCB_DATA_RST;
    end else if (mac_csr_req) begin
      if (mac_csr_ack && mac_csr_read) begin
        mac_csr_wdata <= mac_csr_rdata;
      end
    end else if (access_wr && hit_data) begin
      mac_csr_wdata <= pwdata;
    end
  end

  // ----------------------------------------------------------------------
  // auto pause configuration
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_mark <= `MCB_WM_RST;
      low_mark <= `MCB_WM_RST;
      jam_duration <= `MCB_DUR_RST;
      trigger_on_multicast <= 1'b0;
      trigger_on_broadcast <= 1'b0;
      trigger_on_own_address <= 1'b0;
      trigger_on_every_frame <= 1'b0;
    end else if (access_wr && hit_cfg) begin
      high_mark <= pwdata[`MCB_CFG_HI_MSB:`MCB_CFG_HI_LSB];
      low_mark <= pwdata[`MCB_CFG_LO_MSB:`MCB_CFG_LO_LSB];
      jam_duration <= pwdata[`MCB_CFG_DUR_MSB:`MCB_CFG_DUR_LSB];
      trigger_on_multicast <= pwdata[`MCB_CFG_MULT_BIT];
      trigger_on_broadcast <= pwdata[`MCB_CFG_BRD_BIT];
      trigger_on_own_address <= pwdata[`MCB_CFG_OWN_BIT];
      trigger_on_every_frame <= pwdata[`MCB_CFG_ANY_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // watermark compare
  // ----------------------------------------------------------------------
  assign reached_high = ({2'b00, rx_fifo_bytes} >= mark_bytes(high_mark));
  assign below_low = ({2'b00, rx_fifo_bytes} < mark_bytes(low_mark));

  // full duplex pause only via the any-frame trigger
  assign fd_enabled = tx_enable & full_duplex & trigger_on_every_frame;
  assign hd_enabled = tx_enable & ~full_duplex;

  // ----------------------------------------------------------------------
  // full duplex pause sequencer
  // ----------------------------------------------------------------------
  always @* begin
    next_fc_state = fc_state;
    next_pause_pending = pause_pending;
    next_pause_time = pause_time;
    if (pause_pending && pause_ack) begin
      next_pause_pending = 1'b0;
    end
    if (!tx_enable) begin
      next_pause_pending = 1'b0;
    end
    case (fc_state)
      FC_IDLE: begin
        if (fd_enabled && reached_high && !pause_pending) begin
          next_pause_pending = 1'b1;
          next_pause_time = pause_time_value;
          next_fc_state = FC_PAUSED;
        end
      end
      FC_PAUSED: begin
        if (!full_duplex || !trigger_on_every_frame) begin
          next_fc_state = FC_IDLE;
        end else if (fd_enabled && below_low && !pause_pending) begin
          next_pause_pending = 1'b1;
          next_pause_time = 16'h0000;
          next_fc_state = FC_IDLE;
        end
      end
      default: begin
        next_fc_state = FC_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fc_state <= FC_IDLE;
      pause_pending <= 1'b0;
      pause_time <= 16'h0000;
    end else begin
      fc_state <= next_fc_state;
      pause_pending <= next_pause_pending;
      pause_time <= next_pause_time;
    end
  end

  assign pause_req = pause_pending & tx_enable;

  // ----------------------------------------------------------------------
  // half duplex back pressure
  // ----------------------------------------------------------------------
  assign frame_match = (trigger_on_multicast & rx_is_multicast) |
                       (trigger_on_broadcast & rx_is_broadcast) |
                       (trigger_on_own_address & rx_is_own);

  // any-frame trigger starts at preamble and masks the address triggers
  assign jam_start = hd_enabled & reached_high &
                     (trigger_on_every_frame ? rx_preamble :
                      (rx_addr_done & frame_match));

  mcb_jam_timer #(
    .CYC_PER_US(CYC_PER_US)
  ) u_jam_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(jam_start),
    .cancel(~hd_enabled),
    .code(jam_duration),
    .speed_100(speed_100),
    .active(jam_active)
  );

  assign back_pressure = jam_active & hd_enabled;

endmodule // mcb_top

/* verification/mcb_mac_model.sv */
// behavioural mac register space and pause frame sink facing the block
`timescale 1ns/100ps
module mcb_mac_model (
  input wire pclk,
  input wire presetn,
  input wire mac_csr_req,
  input wire mac_csr_read,
  input wire [7:0] mac_csr_index,
  input wire [31:0] mac_csr_wdata,
  output reg [31:0] mac_csr_rdata,
  output reg mac_csr_ack,
  input wire pause_req,
  output reg pause_ack
);
  reg [31:0] mem [0:255];
  reg [2:0] wt;
  reg [1:0] pw;
  integer i;
  initial for (i = 0; i < 256; i = i + 1) mem[i] = {4{i[7:0]}} ^ 32'h5A5A5A5A;
  // ----------------------------------------------------------------------
  // odd index answers slowly, even index promptly
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wt <= 3'h0;
      pw <= 2'h0;
      mac_csr_ack <= 1'b0;
      pause_ack <= 1'b0;
      mac_csr_rdata <= 32'h00000000;
    end else begin
      wt <= (mac_csr_req && !mac_csr_ack) ? wt + 3'h1 : 3'h0;
      pw <= (pause_req && !pause_ack) ? pw + 2'h1 : 2'h0;
      pause_ack <= pause_req && !pause_ack && pw == 2'h2;
      mac_csr_ack <= mac_csr_req && !mac_csr_ack && wt == (mac_csr_index[0] ? 3'h6 : 3'h1);
      mac_csr_rdata <= ~mac_csr_rdata;
      if (mac_csr_req && !mac_csr_ack && wt == (mac_csr_index[0] ? 3'h6 : 3'h1)) begin
        if (mac_csr_read) mac_csr_rdata <= mem[mac_csr_index];
        else mem[mac_csr_index] <= mac_csr_wdata;
      end
    end
  end
endmodule // mcb_mac_model

/* verification/mcb_top_properties.sv */
// port-level checker for the csr bridge and auto pause block
`timescale 1ns/100ps
`include "mcb_map.vh"
module mcb_top_properties #(
  parameter LEVEL_W = 14
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire mac_csr_req,
  input wire mac_csr_read,
  input wire [7:0] mac_csr_index,
  input wire [31:0] mac_csr_wdata,
  input wire [31:0] mac_csr_rdata,
  input wire mac_csr_ack,
  input wire tx_enable,
  input wire full_duplex,
  input wire speed_100,
  input wire [LEVEL_W-1:0] rx_fifo_bytes,
  input wire [15:0] pause_time_value,
  input wire rx_preamble,
  input wire rx_addr_done,
  input wire rx_is_multicast,
  input wire rx_is_broadcast,
  input wire rx_is_own,
  input wire pause_req,
  input wire [15:0] pause_time,
  input wire pause_ack,
  input wire back_pressure
);
  wire cmd_wr = psel && penable && pwrite && paddr == `MCB_CSR_CMD_OFS;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_busy_launch:
    assert property (cmd_wr && pwdata[31] && !mac_csr_req |=> mac_csr_req
      && mac_csr_read == $past(pwdata[30]) && mac_csr_index == $past(pwdata[7:0]))
    else $error("bridge access not launched");
  chk_no_launch:
    assert property (cmd_wr && !pwdata[31] && !mac_csr_req |=> !mac_csr_req)
    else $error("bridge launched without busy bit");
  chk_busy_hold:
    assert property (mac_csr_req && !mac_csr_ack |=> mac_csr_req
      && $stable(mac_csr_index) && $stable(mac_csr_wdata))
    else $error("busy dropped or request moved early");
  chk_busy_clear:
    assert property (mac_csr_req && mac_csr_ack |=> !mac_csr_req)
    else $error("busy not cleared on completion");
  chk_read_load:
    assert property (mac_csr_req && mac_csr_ack && mac_csr_read
      |=> mac_csr_wdata == $past(mac_csr_rdata))
    else $error("read result not loaded");
  chk_tx_quiet:
    assert property (!tx_enable |-> !pause_req && !back_pressure)
    else $error("flow control with transmitter off");
  chk_fd_no_jam:
    assert property (full_duplex |-> !back_pressure)
    else $error("back pressure in full duplex");
  chk_pause_hold:
    assert property (pause_req && !pause_ack
      |=> !tx_enable || (pause_req && $stable(pause_time)))
    else $error("pause request not held");
  chk_rsvd_zero:
    assert property (psel && penable && !pwrite && paddr == `MCB_CSR_CMD_OFS
      |-> prdata[29:8] == 22'h000000)
    else $error("reserved command bits not zero");
  chk_pause_time_load:
    assert property ($rose(pause_req)
      |-> pause_time == $past(pause_time_value) || pause_time == 16'h0000)
    else $error("pause frame time not loaded");
endmodule // mcb_top_properties
bind mcb_top mcb_top_properties #(.LEVEL_W(LEVEL_W)) i_mcb_top_properties (.*);

/* verification/tb.sv */
// self-checking bench for the csr bridge and auto pause block
`timescale 1ns/100ps
`include "mcb_map.vh"
module tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  reg tx_enable = 0, full_duplex = 0, speed_100 = 1, rx_preamble = 0, rx_addr_done = 0;
  reg rx_is_multicast = 0, rx_is_broadcast = 0, rx_is_own = 0;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [13:0] rx_fifo_bytes = 0;
  reg [15:0] pause_time_value = 16'h0BEE, last_pt;
  wire [31:0] prdata, mac_csr_wdata, mac_csr_rdata;
  wire [7:0] mac_csr_index;
  wire [15:0] pause_time;
  wire pready, pslverr, mac_csr_req, mac_csr_read, mac_csr_ack;
  wire pause_req, pause_ack, back_pressure;
  integer n_fail = 0, num_checks = 0, n_pause = 0, i, n, c;
  mcb_top #(.CYC_PER_US(1)) i_mcb_top (.*);
  mcb_mac_model i_mcb_mac_model (.*);
  initial forever #20 pclk = ~pclk;
  initial begin
    repeat (60000) @(posedge pclk);
    n_fail = n_fail + 1;
    report_and_stop;
  end
  always @(posedge pclk) if (pause_ack === 1'b1) begin
    n_pause <= n_pause + 1;
    last_pt <= pause_time;
  end
  // ----------------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------------
  task report_and_stop;
    begin
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task idle_bridge;
    begin
      rd = 32'h80000000;
      while (rd[31] !== 1'b0) apb(1'b0, `MCB_CSR_CMD_OFS, 32'h0);
    end
  endtask
  task lvl(input [13:0] v);
    begin
      rx_fifo_bytes <= v;
      repeat (12) @(posedge pclk);
    end
  endtask
  task trig(input p, input [2:0] f);
    begin
      rx_preamble <= p;
      rx_addr_done <= ~p;
      {rx_is_multicast, rx_is_broadcast, rx_is_own} <= f;
      @(posedge pclk);
      rx_preamble <= 1'b0;
      rx_addr_done <= 1'b0;
      n = 0;
      // count settled mid-cycle levels, first jam cycle included
      @(negedge pclk);
      while (back_pressure === 1'b1 && n < 1000) begin
        n = n + 1;
        @(negedge pclk);
      end
      @(posedge pclk);
    end
  endtask
  function integer us(input integer k);
    us = (k == 0) ? 5 : (k == 1) ? 10 : (k == 2) ? 15 : (k == 3) ? 25 : 50 * (k - 3);
  endfunction
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b0, 8'hA4 + 8'h04 * i[7:0], 32'h0);
      chk("rst", rd, 32'h0);
    end
    apb(1'b0, 8'hB0, 32'h0);
    chk("err", {31'h0, err}, 32'h1);
    apb(1'b1, `MCB_CSR_DATA_OFS, 32'h1234ABCD);
    apb(1'b1, `MCB_CSR_CMD_OFS, 32'h80000033);
    chk("idx", {24'h0, mac_csr_index}, 32'h33);
    chk("wdat", mac_csr_wdata, 32'h1234ABCD);
    idle_bridge;
    apb(1'b1, `MCB_CSR_CMD_OFS, 32'hC0000033);
    idle_bridge;
    apb(1'b0, `MCB_CSR_DATA_OFS, 32'h0);
    chk("rback", rd, 32'h1234ABCD);
    apb(1'b1, `MCB_CSR_CMD_OFS, 32'hC0000010);
    idle_bridge;
    apb(1'b0, `MCB_CSR_DATA_OFS, 32'h0);
    chk("rdflt", rd, 32'h4A4A4A4A);
    apb(1'b1, `MCB_CSR_CMD_OFS, 32'h7FFFFF44);
    apb(1'b0, `MCB_CSR_CMD_OFS, 32'h0);
    chk("cmd", rd, 32'h40000044);
    apb(1'b1, `MCB_AUTO_CFG_OFS, 32'hFFFFFEFF);
    apb(1'b0, `MCB_AUTO_CFG_OFS, 32'h0);
    chk("cfg", rd, 32'h00FFFEFF);
    apb(1'b1, `MCB_AUTO_CFG_OFS, 32'h00020101);
    tx_enable <= 1'b1;
    full_duplex <= 1'b1;
    lvl(14'd127);
    chk("np", n_pause, 0);
    lvl(14'd128);
    chk("np", n_pause, 1);
    chk("ptim", last_pt, 32'h0BEE);
    lvl(14'd4000);
    lvl(14'd64);
    chk("np", n_pause, 1);
    lvl(14'd63);
    chk("np", n_pause, 2);
    chk("ptim", last_pt, 32'h0);
    lvl(14'd0);
    tx_enable <= 1'b0;
    lvl(14'd128);
    chk("np", n_pause, 2);
    full_duplex <= 1'b0;
    tx_enable <= 1'b1;
    for (i = 0; i < 6; i = i + 1) begin
      c = (i == 5) ? 15 : i;
      speed_100 <= (i != 5);
      apb(1'b1, `MCB_AUTO_CFG_OFS, 32'h00020101 | (c << 4));
      trig(1'b1, 3'h0);
      chk("jam", n, us(c) + ((i == 5) ? 2 : 0));
    end
    speed_100 <= 1'b1;
    for (i = 1; i < 4; i = i + 1) begin
      apb(1'b1, `MCB_AUTO_CFG_OFS, 32'h00020000 | (1 << i));
      trig(1'b0, 3'h7 ^ (3'h1 << (i - 1)));
      chk("nojam", n, 0);
      trig(1'b0, 3'h1 << (i - 1));
      chk("jam", n, 5);
    end
    lvl(14'd64);
    trig(1'b0, 3'h4);
    chk("nojam", n, 0);
    apb(1'b1, `MCB_AUTO_CFG_OFS, 32'h00020101);
    full_duplex <= 1'b1;
    lvl(14'd128);
    trig(1'b1, 3'h0);
    chk("nojam", n, 0);
    chk("np", n_pause, 3);
    report_and_stop;
  end
endmodule // tb
